// ### src/epc_pkg.sv
// Constants shared by the enhanced parallel port cycle engine.
// Assumes a 200 MHz APB clock; offsets are byte addresses.
package epc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] EPC_DATA_OFS = 8'h00;
  localparam logic [7:0] EPC_STATUS_OFS = 8'h04;
  localparam logic [7:0] EPC_CTRL_OFS = 8'h08;
  localparam logic [7:0] EPC_EADDR_OFS = 8'h0C;
  localparam logic [7:0] EPC_EDATA_OFS = 8'h10;

  // ==========================================================
  // Control fields
  localparam int EPC_CTRL_STROBE = 0;
  localparam int EPC_CTRL_AUTOFD = 1;
  localparam int EPC_CTRL_INIT = 2;
  localparam int EPC_CTRL_SELIN = 3;
  localparam int EPC_CTRL_DIR = 5;
  localparam logic [7:0] EPC_CTRL_RST = 8'h24;
  localparam logic [7:0] EPC_CTRL_MASK = 8'h2F;
  localparam logic [7:0] EPC_DATA_RST = 8'h00;

  // ==========================================================
  // Status fields
  localparam int EPC_ST_TMO = 0;
  localparam int EPC_ST_IRQ_EDGE = 1;
  localparam int EPC_ST_HOLD = 2;
  localparam int EPC_ST_BUSY = 3;
  localparam int EPC_ST_IRQ = 4;

  // ==========================================================
  // Timing
  localparam int EPC_CLK_PERIOD_PS = 5000;
  localparam int EPC_TIMEOUT_PS = 10000000;
  localparam int EPC_TMO_CYC = EPC_TIMEOUT_PS / EPC_CLK_PERIOD_PS;
  localparam int EPC_TMO_W = 12;

  // ==========================================================
  // Cycle state machine
  typedef enum logic [3:0] {
    EPC_IDLE = 4'b0001,
    EPC_SETUP = 4'b0010,
    EPC_HOLD = 4'b0100,
    EPC_DONE = 4'b1000
  } epc_state_t;

endpackage

// ### src/epc_sync.sv
// Two flip-flop synchroniser for pins from outside the clock domain.
// Assumes a constant reset value per bit.
module epc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = en ? d : meta_q;
    q_d = en ? meta_q : q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST;
      q <= RST;
    end else begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end

endmodule

// ### src/epc_timer.sv
// Watchdog for one port cycle: counts while run is high, clears
// when it drops, flags expiry after the programmed number of cycles.
module epc_timer
  import epc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic run,
  output logic expired
);

  logic [EPC_TMO_W-1:0] cnt_q;
  logic [EPC_TMO_W-1:0] cnt_d;
  localparam logic [EPC_TMO_W-1:0] LIMIT = EPC_TMO_W'(EPC_TMO_CYC);

  always_comb begin
    cnt_d = cnt_q;
    if (en) begin
      if (!run)
        cnt_d = '0;
      else if (cnt_q != LIMIT)
        cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign expired = (cnt_q == LIMIT);

endmodule

// ### src/epc_cycle_engine.sv
// Enhanced parallel port cycle engine with APB register access.
// Assumes peripheral pins arrive asynchronously; the port bus wire
// is resolved outside from port_data_out and port_data_oe.
//
// Behaviour
// - Write cycle waits while peripheral hold is low, ends once high.
// - Read cycle waits while peripheral hold is low, ends once high.
// - Write puts byte on bus first, then asserts the chosen strobe.
// - Write ends with ready, strobe release, byte kept on bus.
// - Read asserts strobe with drivers off and write indication valid.
// - Cycle waits until peripheral releases hold or timeout, first wins.
// - Read ends with ready returned and strobe released.
// - Peripheral interrupt is active high, rising edge, passed uninverted.
// - Active-low peripheral init output returns peripheral to start mode.
// - Address strobe only for address cycles, data strobe for data.
// - Write indication low only for write operations.
// - Only control strobe bit may override write indication in cycles.
// - Standard and enhanced modes share one data register.
// - Cycle over ten microseconds aborts and sets status bit zero.
// - Outside cycles, outputs follow the standard control register.
module epc_cycle_engine
  import epc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_data_in,
  output logic [7:0] port_data_out,
  output logic port_data_oe,
  input wire logic peripheral_hold_n,
  input wire logic peripheral_interrupt_in,
  output logic peripheral_interrupt,
  output logic data_strobe_n,
  output logic addr_strobe_n,
  output logic write_indication_n,
  output logic peripheral_init_n
);

  // ==========================================================
  // Pin synchronisers
  logic [7:0] bus_s;
  logic hold_s;
  logic irq_s;

  epc_sync #(.W(10), .RST(10'h0_100)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .en(pclken),
    .d({peripheral_interrupt_in, peripheral_hold_n, port_data_in}),
    .q({irq_s, hold_s, bus_s})
  );

  // ==========================================================
  // APB decode
  logic setup_ph;
  logic access_ph;
  logic hit_data, hit_status, hit_ctrl, hit_eaddr, hit_edata;
  logic hit_epp;
  logic mapped;

  always_comb begin
    setup_ph = psel && !penable;
    access_ph = psel && penable;
    hit_data = (paddr == EPC_DATA_OFS);
    hit_status = (paddr == EPC_STATUS_OFS);
    hit_ctrl = (paddr == EPC_CTRL_OFS);
    hit_eaddr = (paddr == EPC_EADDR_OFS);
    hit_edata = (paddr == EPC_EDATA_OFS);
    hit_epp = hit_eaddr || hit_edata;
    mapped = hit_data || hit_status || hit_ctrl || hit_epp;
  end

  // ==========================================================
  // Cycle state
  epc_state_t state_q, state_d;
  logic cyc_addr_q, cyc_addr_d;
  logic cyc_rd_q, cyc_rd_d;
  logic tmo;
  logic in_cycle;
  logic take;
  logic finish;

  epc_timer u_timer (
    .clk(pclk),
    .rst_n(presetn),
    .en(pclken),
    .run(state_q == EPC_SETUP || state_q == EPC_HOLD),
    .expired(tmo)
  );

  // ==========================================================
  // Registers
  logic [7:0] data_q, data_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic tmo_flag_q, tmo_flag_d;
  logic irq_edge_q, irq_edge_d;
  logic irq_prev_q;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0] status;

  assign in_cycle = (state_q != EPC_IDLE);
  assign take = access_ph && hit_epp && (state_q == EPC_IDLE);
  // Hold release or watchdog, whichever comes first
  assign finish = (state_q == EPC_HOLD) && (hold_s || tmo);

  always_comb begin
    status = '0;
    status[EPC_ST_TMO] = tmo_flag_q;
    status[EPC_ST_IRQ_EDGE] = irq_edge_q;
    status[EPC_ST_HOLD] = hold_s;
    status[EPC_ST_BUSY] = in_cycle;
    status[EPC_ST_IRQ] = irq_s;
  end

  always_comb begin
    state_d = state_q;
    cyc_addr_d = cyc_addr_q;
    cyc_rd_d = cyc_rd_q;
    case (state_q)
      EPC_IDLE: begin
        if (take) begin
          state_d = EPC_SETUP;
          cyc_addr_d = hit_eaddr;
          // Direction bit, not pwrite, steers the bus: a write with
          // the bit set runs as a read, with no error.
          cyc_rd_d = ctrl_q[EPC_CTRL_DIR];
        end
      end
      EPC_SETUP: state_d = EPC_HOLD;
      EPC_HOLD: begin
        if (finish)
          state_d = EPC_DONE;
      end
      EPC_DONE: state_d = EPC_IDLE;
      default: state_d = EPC_IDLE;
    endcase
  end

  always_comb begin
    data_d = data_q;
    ctrl_d = ctrl_q;
    tmo_flag_d = tmo_flag_q;
    irq_edge_d = irq_edge_q;
    prdata_d = prdata_q;
    if (access_ph && pwrite && pready) begin
      if (hit_data)
        data_d = pwdata[7:0];
      if (hit_ctrl)
        ctrl_d = pwdata[7:0] & EPC_CTRL_MASK;
      if (hit_status && pwdata[EPC_ST_TMO])
        tmo_flag_d = 1'b0;
      if (hit_status && pwdata[EPC_ST_IRQ_EDGE])
        irq_edge_d = 1'b0;
    end
    // Enhanced write shares the standard data register
    if (take && pwrite && !ctrl_q[EPC_CTRL_DIR])
      data_d = pwdata[7:0];
    if (finish && cyc_rd_q) begin
      data_d = bus_s;
      prdata_d = {24'h00_0000, bus_s};
    end
    if (setup_ph) begin
      prdata_d = '0;
      if (hit_data)
        prdata_d[7:0] = ctrl_q[EPC_CTRL_DIR] ? bus_s : data_q;
      if (hit_ctrl)
        prdata_d[7:0] = ctrl_q;
      if (hit_status)
        prdata_d[7:0] = status;
      if (hit_epp)
        prdata_d[7:0] = data_q;
    end
    // Set wins over a clear in the same cycle
    if (finish && tmo && !hold_s)
      tmo_flag_d = 1'b1;
    if (irq_s && !irq_prev_q)
      irq_edge_d = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= EPC_IDLE;
      cyc_addr_q <= 1'b0;
      cyc_rd_q <= 1'b1;
      data_q <= EPC_DATA_RST;
      ctrl_q <= EPC_CTRL_RST;
      tmo_flag_q <= 1'b0;
      irq_edge_q <= 1'b0;
      irq_prev_q <= 1'b0;
      prdata_q <= '0;
    end else if (pclken) begin
      state_q <= state_d;
      cyc_addr_q <= cyc_addr_d;
      cyc_rd_q <= cyc_rd_d;
      data_q <= data_d;
      ctrl_q <= ctrl_d;
      tmo_flag_q <= tmo_flag_d;
      irq_edge_q <= irq_edge_d;
      irq_prev_q <= irq_s;
      prdata_q <= prdata_d;
    end
  end

  // ==========================================================
  // Bus answer: enhanced ports wait until the cycle's final state
  always_comb begin
    pready = 1'b1;
    if (hit_epp)
      pready = (state_q == EPC_DONE);
    pslverr = access_ph && !mapped;
  end
  assign prdata = prdata_q;

  // ==========================================================
  // Port pins
  logic strobe_on;
  assign strobe_on = (state_q == EPC_HOLD);

  always_comb begin
    port_data_out = data_q;
    if (in_cycle) begin
      port_data_oe = !cyc_rd_q;
      data_strobe_n = !(strobe_on && !cyc_addr_q);
      addr_strobe_n = !(strobe_on && cyc_addr_q);
    end else begin
      port_data_oe = !ctrl_q[EPC_CTRL_DIR];
      data_strobe_n = !ctrl_q[EPC_CTRL_AUTOFD];
      addr_strobe_n = !ctrl_q[EPC_CTRL_SELIN];
    end
    // Only the control strobe bit may force a write indication
    write_indication_n = ctrl_q[EPC_CTRL_DIR] &&
      !ctrl_q[EPC_CTRL_STROBE];
    peripheral_init_n = ctrl_q[EPC_CTRL_INIT];
    peripheral_interrupt = irq_s;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hold_extends_a: assert property (
    (state_q == EPC_HOLD) && !hold_s && !tmo && pclken
    |=> (state_q == EPC_HOLD) && !pready)
    else $error("cycle ended while peripheral hold low");

  release_done_a: assert property (
    (state_q == EPC_HOLD) && (hold_s || tmo) && pclken
    |=> (state_q == EPC_DONE) ##1 !in_cycle || !pclken)
    else $error("cycle did not end after release");

  write_order_a: assert property (
    (state_q == EPC_SETUP) && !cyc_rd_q
    |-> port_data_oe && data_strobe_n && addr_strobe_n)
    else $error("strobe before data on write");

  read_float_a: assert property (
    strobe_on && cyc_rd_q |-> !port_data_oe && write_indication_n)
    else $error("drivers on during read strobe");

  done_release_a: assert property (
    (state_q == EPC_DONE)
    |-> data_strobe_n && addr_strobe_n && (!hit_epp || pready))
    else $error("strobe held at cycle end");

  strobe_kind_a: assert property (
    strobe_on |-> (addr_strobe_n != data_strobe_n)
      && (addr_strobe_n == !cyc_addr_q))
    else $error("wrong strobe for cycle kind");

  write_ind_a: assert property (
    !write_indication_n
    |-> !ctrl_q[EPC_CTRL_DIR] || ctrl_q[EPC_CTRL_STROBE])
    else $error("write indication without write");

  timeout_flag_a: assert property (
    strobe_on && tmo && !hold_s && pclken |=> tmo_flag_q)
    else $error("timeout not recorded");

  shared_data_a: assert property (
    take && pwrite && !ctrl_q[EPC_CTRL_DIR] && pclken
    |=> port_data_out == $past(pwdata[7:0]))
    else $error("enhanced write missed data register");

  irq_pass_a: assert property (
    peripheral_interrupt == irq_s)
    else $error("interrupt not passed through");

  init_out_a: assert property (
    peripheral_init_n == ctrl_q[EPC_CTRL_INIT])
    else $error("init output differs from control");

endmodule

// ### bench/epc_periph_model.sv
// Behavioural peripheral on the far side of the parallel port bus.
// Assumes the bench clocks it from the engine's clock and reset.
module epc_periph_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic data_strobe_n,
  input wire logic addr_strobe_n,
  input wire logic write_indication_n,
  input wire logic [7:0] port_data_out,
  input wire logic port_data_oe,
  input wire logic [15:0] delay,
  input wire logic [7:0] rd_byte,
  output logic [7:0] port_data_in,
  output logic peripheral_hold_n,
  output logic [7:0] got_byte,
  output logic got_addr,
  output logic bad
);
  logic act;
  logic drv_q;
  logic [7:0] last_q;
  logic [15:0] cnt_q;
  assign act = !data_strobe_n || !addr_strobe_n;
  // No pull-up: a floating bus shows a changing pattern, not old data
  assign port_data_in = port_data_oe ? port_data_out :
                        drv_q ? rd_byte : ~last_q;
  // ==========================================================
  // Handshake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      drv_q <= 1'b0;
      last_q <= 8'h00;
      peripheral_hold_n <= 1'b0;
      got_byte <= 8'h00;
      got_addr <= 1'b0;
      bad <= 1'b0;
    end else begin
      cnt_q <= act ? cnt_q + 16'h0001 : 16'h0000;
      // Low while idle means ready; high acknowledges the strobe
      peripheral_hold_n <= act && cnt_q >= delay;
      drv_q <= act && write_indication_n;
      last_q <= port_data_in;
      if (act && !write_indication_n) begin
        got_byte <= port_data_in;
        got_addr <= !addr_strobe_n;
      end
      if (act && (port_data_oe == write_indication_n ||
          (!data_strobe_n && !addr_strobe_n))) begin
        bad <= 1'b1;
      end
    end
  end
endmodule

// ### bench/tb_epp17_cycle_engine.sv
// Self-checking bench for the parallel port cycle engine.
// Assumes the peripheral model file is compiled before this one.
module tb_epp17_cycle_engine;
  timeunit 1ns;
  timeprecision 1ps;
  import epc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, port_data_in, port_data_out, rd_byte, got_byte;
  logic [31:0] pwdata, prdata, r;
  logic port_data_oe, peripheral_hold_n, irq_in, peripheral_interrupt;
  logic data_strobe_n, addr_strobe_n, write_indication_n;
  logic peripheral_init_n, got_addr, bad, e;
  logic [15:0] delay;
  int failures, checked, n;

  epc_cycle_engine dut_u (.pclk(pclk), .presetn(presetn),
    .pclken(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_data_in(port_data_in),
    .port_data_out(port_data_out), .port_data_oe(port_data_oe),
    .peripheral_hold_n(peripheral_hold_n),
    .peripheral_interrupt_in(irq_in),
    .peripheral_interrupt(peripheral_interrupt),
    .data_strobe_n(data_strobe_n), .addr_strobe_n(addr_strobe_n),
    .write_indication_n(write_indication_n),
    .peripheral_init_n(peripheral_init_n));
  epc_periph_model peer_u (.pclk(pclk), .presetn(presetn),
    .data_strobe_n(data_strobe_n), .addr_strobe_n(addr_strobe_n),
    .write_indication_n(write_indication_n),
    .port_data_out(port_data_out), .port_data_oe(port_data_oe),
    .delay(delay), .rd_byte(rd_byte), .port_data_in(port_data_in),
    .peripheral_hold_n(peripheral_hold_n), .got_byte(got_byte),
    .got_addr(got_addr), .bad(bad));

  // ==========================================================
  // Helpers
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request stands until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Callers compare outputs only after the edge's updates settle
    @(negedge pclk);
    if (n >= 5000) begin
      failures++;
      close_out();
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk({data_strobe_n, addr_strobe_n, write_indication_n}, 3'h7);
    chk(port_data_oe, 1'b0);
    chk(peripheral_init_n, 1'b1);
    apb(1'b0, EPC_CTRL_OFS, 32'h0000_0000);
    chk(r, 32'h0000_0024);
  endtask

  task automatic t_write();
    apb(1'b1, EPC_CTRL_OFS, 32'h0000_0000);
    chk(write_indication_n, 1'b0);
    delay = 16'h0006;
    apb(1'b1, EPC_EDATA_OFS, 32'h0000_00A5);
    chk(n > 6, 1'b1);
    chk({got_addr, got_byte}, 9'h0A5);
    chk(port_data_out, 8'hA5);
    chk({data_strobe_n, addr_strobe_n}, 2'h3);
    apb(1'b0, EPC_DATA_OFS, 32'h0000_0000);
    chk(r, 32'h0000_00A5);
    apb(1'b1, EPC_EADDR_OFS, 32'h0000_003C);
    chk({got_addr, got_byte}, 9'h13C);
  endtask

  task automatic t_read();
    apb(1'b1, EPC_CTRL_OFS, 32'h0000_0020);
    chk({write_indication_n, port_data_oe}, 2'h2);
    delay = 16'h0004;
    rd_byte = 8'h5A;
    apb(1'b0, EPC_EDATA_OFS, 32'h0000_0000);
    chk(r, 32'h0000_005A);
    chk(n > 4, 1'b1);
    chk({data_strobe_n, addr_strobe_n}, 2'h3);
    rd_byte = 8'hC3;
    apb(1'b0, EPC_EADDR_OFS, 32'h0000_0000);
    chk(r, 32'h0000_00C3);
    chk(bad, 1'b0);
  endtask

  task automatic t_override();
    apb(1'b1, EPC_CTRL_OFS, 32'h0000_0021);
    chk(write_indication_n, 1'b0);
    apb(1'b1, EPC_CTRL_OFS, 32'h0000_0022);
    chk({data_strobe_n, addr_strobe_n, port_data_oe}, 3'h2);
    apb(1'b1, EPC_CTRL_OFS, 32'h0000_0020);
    chk(write_indication_n, 1'b1);
  endtask

  task automatic t_timeout();
    apb(1'b1, EPC_CTRL_OFS, 32'h0000_0000);
    delay = 16'hFFFF;
    apb(1'b1, EPC_EDATA_OFS, 32'h0000_0011);
    chk(n >= 1990 && n <= 2010, 1'b1);
    apb(1'b0, EPC_STATUS_OFS, 32'h0000_0000);
    chk(r[EPC_ST_TMO], 1'b1);
    apb(1'b1, EPC_STATUS_OFS, 32'h0000_0001);
    apb(1'b0, EPC_STATUS_OFS, 32'h0000_0000);
    chk(r[EPC_ST_TMO], 1'b0);
    delay = 16'h0002;
  endtask

  task automatic t_misc();
    @(posedge pclk);
    irq_in <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(peripheral_interrupt, 1'b1);
    irq_in <= 1'b0;
    apb(1'b0, EPC_STATUS_OFS, 32'h0000_0000);
    chk(r[EPC_ST_IRQ_EDGE], 1'b1);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(e, 1'b1);
    chk(r, 32'h0000_0000);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, irq_in} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    delay = 16'h0002;
    rd_byte = 8'h00;
    failures = 0;
    checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_write();
    t_read();
    t_override();
    t_timeout();
    t_misc();
    close_out();
  end
endmodule
